/* File: rtl/lstir_pkg.sv */
// constants, states and timer decoding for the aux led sink register block
// assumes a 100 MHz core clock and a 100 us timer tick
package lstir_pkg;
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 100;
  localparam int TICK_CYCLES_DEF = TICK_US * CLK_MHZ;
  localparam int TICKS_PER_MS = 1000 / TICK_US;
  localparam int RST_DEB_US = 75;
  localparam int RST_DEB_CYCLES_DEF = RST_DEB_US * CLK_MHZ + 1;
  localparam int INT_GAP_US = 50;
  localparam int INT_GAP_CYCLES_DEF = INT_GAP_US * CLK_MHZ;
  localparam int NREG = 23;
  localparam int CODE_W = 6;
  localparam int CODE_SPAN = 63;
  localparam logic [6:0] DEV_ADDR = 7'h32;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_IRQ_EN = 8'h01;
  localparam logic [7:0] REG_BL_CODE = 8'h0B;
  localparam logic [7:0] REG_SINK_CFG = 8'h11;
  localparam logic [7:0] REG_BLINK = 8'h12;
  localparam logic [7:0] REG_RAMP = 8'h13;
  localparam logic [7:0] REG_SINK0 = 8'h14;
  localparam logic [7:0] REG_LAST = 8'h16;
  localparam int MODE_OVP_BIT = 4;
  localparam int MODE_CMPR_BIT = 3;
  localparam int IEN_OVP_BIT = 2;
  localparam int IEN_CMPR_BIT = 3;
  localparam int CURVE_BIT = 3;
  localparam logic [7:0] MODE_RW_MASK = 8'hE0;
  localparam logic [7:0] IEN_RW_MASK = 8'h1C;
  localparam logic [7:0] CODE_RW_MASK = 8'h3F;

  typedef enum logic [3:0] {
    I_IDLE, I_ADDR, I_ACK_ADDR, I_REG, I_ACK_REG,
    I_WDATA, I_ACK_DATA, I_READ, I_READ_ACK
  } lstir_i2c_type;

  // ticks per one-code ramp step; 0 means ramp disabled
  function automatic logic [15:0] ramp_step_ticks(input logic [3:0] sel);
    int ms;
    ms = 0;
    case (sel)
      4'h1: ms = 300;
      4'h2: ms = 500;
      4'h3: ms = 800;
      4'h4: ms = 1100;
      4'h5: ms = 1500;
      4'h6: ms = 1800;
      4'h7: ms = 2100;
      4'h8: ms = 2400;
      4'h9: ms = 2800;
      4'hA: ms = 3100;
      4'hB: ms = 3400;
      4'hC: ms = 3800;
      4'hD: ms = 4200;
      4'hE: ms = 4600;
      4'hF: ms = 5500;
      default: ms = 0;
    endcase
    return 16'((ms * TICKS_PER_MS) / CODE_SPAN);
  endfunction

  // blink phase length in ticks; dark setting 0 means blink off
  function automatic logic [15:0] blink_ticks(input logic [1:0] sel,
                                              input logic lit);
    int ms;
    ms = 0;
    case (sel)
      2'h0: ms = lit ? 200 : 0;
      2'h1: ms = 600;
      2'h2: ms = 800;
      default: ms = 1200;
    endcase
    return 16'(ms * TICKS_PER_MS);
  endfunction
endpackage

/* File: rtl/lstir_top.sv */
// aux led sink timing, interrupt pin, hard reset pin and two-wire
// register slave of the led driver control logic
// assumes scl, sda and the reset pin are asynchronous and event
// inputs and the backlight code come from logic on clk
`timescale 1ns/1ps

// Summary of operation
// (RULE1) one ramp-up and one ramp-down timer in register 0x13 serve all sinks
// (RULE2) ramp timers take fifteen settings from 0.3 s to 5.5 s
// (RULE3) ramp time covers the full code span; shorter swings end sooner
// (RULE4) host sets timers before enabling any sink in 0x11
// (RULE5) curve select 0 gives linear code ramping
// (RULE6) curve select 1 gives square-law codes with identical ramp timing
// (RULE7) blink uses one shared lit timer in 0x12 plus one dark timer per sink
// (RULE8) lit timer selects 0.2, 0.6, 0.8 or 1.2 s
// (RULE9) dark timer selects off, 0.6, 0.8 or 1.2 s; nonzero enables blink
// (RULE10) enable cleared while lit turns sink off, ramping down if timed
// (RULE11) enable cleared while dark keeps sink off with no new lit phase
// (RULE12) interrupt pin is open drain, pulled low only to assert
// (RULE13) reset pin debounced; low over 75 us restores reset state
// (RULE14) write is start, 0x64, register byte, data byte, stop
// (RULE15) device acks address, register and data bytes by pulling sda low
// (RULE16) read is write phase, repeated start, then 0x65
// (RULE17) read returns the register addressed in the write phase
// (RULE18) master nacks the read byte and ends with stop
// (RULE19) all registers reset to zero; unused bits read zero
// (RULE20) register 0x0B is read only and shows the applied backlight code
// (RULE21) register 0x01 enables sources; only enabled pending flags assert
// (RULE22) sink codes are six bits, 64 levels
// (RULE23) clearing one flag with another pending releases the pin 50 us
// (RULE24) ramps step one code per period of duration over span
// (RULE25) addresses above 0x16 ack, ignore writes and read zero
module lstir_top #(
  parameter int unsigned TICK_CYCLES = lstir_pkg::TICK_CYCLES_DEF,
  parameter int unsigned RST_DEB_CYCLES = lstir_pkg::RST_DEB_CYCLES_DEF,
  parameter int unsigned INT_GAP_CYCLES = lstir_pkg::INT_GAP_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rst_pin_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic int_n_out,
  output logic int_n_oe,
  input wire logic ovp_event,
  input wire logic cmpr_event,
  input wire logic [6:0] bl_applied_code,
  output logic [lstir_pkg::CODE_W-1:0] aux_sink_code0,
  output logic [lstir_pkg::CODE_W-1:0] aux_sink_code1,
  output logic [lstir_pkg::CODE_W-1:0] aux_sink_code2,
  output logic aux_curve_select
);
  import lstir_pkg::*;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_q;
    logic sda_s1;
    logic sda_s2;
    logic sda_q;
    logic rp_s1;
    logic rp_s2;
    logic [15:0] deb;
    logic [15:0] tick_cnt;
    logic tick;
    lstir_i2c_type st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic drive;
    logic [NREG-1:0][7:0] regs;
    logic [15:0] gap;
    logic int_on;
    logic [2:0][CODE_W-1:0] code;
    logic [2:0][15:0] stepc;
    logic [2:0][15:0] bcnt;
    logic [2:0] lit;
  } lstir_state_type;

  lstir_state_type s;
  lstir_state_type next_s;
  logic [1:0] rsync;
  logic rst_sync_n;
  logic hold;

  function automatic logic pend(input logic [NREG-1:0][7:0] r);
    return (r[REG_MODE][MODE_OVP_BIT] & r[REG_IRQ_EN][IEN_OVP_BIT]) |
           (r[REG_MODE][MODE_CMPR_BIT] & r[REG_IRQ_EN][IEN_CMPR_BIT]);
  endfunction

  function automatic logic [7:0] rd_value(input lstir_state_type q,
                                          input logic [6:0] blc);
    if (q.ptr == REG_BL_CODE)
      return {1'b0, blc}; // [RULE20]
    else if (q.ptr <= REG_LAST)
      return q.regs[q.ptr[4:0]]; // [RULE17]
    else
      return 8'h00; // [RULE25]
  endfunction

  function automatic logic [7:0] wr_mask(input logic [7:0] a);
    if (a == REG_MODE)
      return MODE_RW_MASK;
    else if (a == REG_IRQ_EN)
      return IEN_RW_MASK;
    else if (a == REG_BL_CODE || a > REG_LAST)
      return 8'h00; // [RULE20] [RULE25]
    else if (a >= REG_SINK0)
      return CODE_RW_MASK; // [RULE22]
    else
      return 8'hFF;
  endfunction

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rsync <= 2'h0;
    else
      rsync <= {rsync[0], 1'b1};
  end
  assign rst_sync_n = rsync[1];
  assign hold = (s.deb == 16'(RST_DEB_CYCLES));

  always_comb
  begin
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic en;
    logic [1:0] dsel;
    logic [5:0] tgt;
    logic [15:0] per;
    logic [7:0] rv;
    logic [7:0] m;
    scl_rise = s.scl_s2 & ~s.scl_q;
    scl_fall = ~s.scl_s2 & s.scl_q;
    start_c = s.scl_s2 & s.scl_q & s.sda_q & ~s.sda_s2;
    stop_c = s.scl_s2 & s.scl_q & ~s.sda_q & s.sda_s2;
    en = 1'b0;
    dsel = 2'h0;
    tgt = 6'h00;
    per = 16'h0000;
    rv = rd_value(s, bl_applied_code);
    m = wr_mask(s.ptr);
    next_s = s;
    next_s.scl_s1 = scl;
    next_s.scl_s2 = s.scl_s1;
    next_s.scl_q = s.scl_s2;
    next_s.sda_s1 = sda_in;
    next_s.sda_s2 = s.sda_s1;
    next_s.sda_q = s.sda_s2;
    next_s.rp_s1 = rst_pin_n;
    next_s.rp_s2 = s.rp_s1;
    // hard reset pin debounce
    if (s.rp_s2)
      next_s.deb = 16'h0000;
    else if (!hold)
      next_s.deb = s.deb + 16'h0001; // [RULE13]
    next_s.tick = 1'b0;
    if (s.tick_cnt == 16'(TICK_CYCLES - 1))
    begin
      next_s.tick_cnt = 16'h0000;
      next_s.tick = 1'b1;
    end
    else
      next_s.tick_cnt = s.tick_cnt + 16'h0001;

    // two-wire slave
    if (start_c)
    begin
      next_s.st = I_ADDR;
      next_s.cnt = 4'h0;
      next_s.drive = 1'b0;
    end
    else if (stop_c)
    begin
      next_s.st = I_IDLE;
      next_s.drive = 1'b0;
    end
    else
    begin
      unique case (s.st)
        I_IDLE:
          next_s.drive = 1'b0;
        I_ADDR, I_REG, I_WDATA:
          if (scl_rise)
          begin
            next_s.sh = {s.sh[6:0], s.sda_s2};
            next_s.cnt = s.cnt + 4'h1;
          end
          else if (scl_fall && s.cnt == 4'h8)
          begin
            next_s.cnt = 4'h0;
            next_s.drive = 1'b1; // [RULE15]
            if (s.st == I_ADDR)
            begin
              next_s.rw = s.sh[0];
              next_s.st = I_ACK_ADDR;
              if (s.sh[7:1] != DEV_ADDR)
              begin
                next_s.drive = 1'b0;
                next_s.st = I_IDLE;
              end
            end
            else if (s.st == I_REG)
            begin
              next_s.ptr = s.sh;
              next_s.st = I_ACK_REG;
            end
            else
            begin
              if (s.ptr <= REG_LAST)
                next_s.regs[s.ptr[4:0]] =
                  (s.regs[s.ptr[4:0]] & ~m) | (s.sh & m); // [RULE25]
              if (s.ptr == REG_MODE)
              begin
                if (s.sh[MODE_OVP_BIT])
                  next_s.regs[REG_MODE][MODE_OVP_BIT] = 1'b0;
                if (s.sh[MODE_CMPR_BIT])
                  next_s.regs[REG_MODE][MODE_CMPR_BIT] = 1'b0;
              end
              next_s.st = I_ACK_DATA;
            end
          end
        I_ACK_ADDR, I_ACK_REG, I_ACK_DATA:
          if (scl_fall)
          begin
            if (s.st == I_ACK_ADDR && s.rw)
            begin
              next_s.sh = rv; // [RULE17]
              next_s.drive = ~rv[7];
              next_s.cnt = 4'h1;
              next_s.st = I_READ;
            end
            else
            begin
              next_s.drive = 1'b0;
              next_s.st = (s.st == I_ACK_ADDR) ? I_REG : I_WDATA;
            end
          end
        I_READ:
          if (scl_fall)
          begin
            if (s.cnt == 4'h8)
            begin
              next_s.drive = 1'b0;
              next_s.st = I_READ_ACK;
            end
            else
            begin
              next_s.sh = {s.sh[6:0], 1'b0};
              next_s.drive = ~s.sh[6];
              next_s.cnt = s.cnt + 4'h1;
            end
          end
        I_READ_ACK:
          if (scl_rise)
            next_s.st = s.sda_s2 ? I_IDLE : I_ACK_ADDR; // [RULE18]
      endcase
    end

    // flags: a hardware set wins over a same-cycle clear
    if (ovp_event)
      next_s.regs[REG_MODE][MODE_OVP_BIT] = 1'b1;
    if (cmpr_event)
      next_s.regs[REG_MODE][MODE_CMPR_BIT] = 1'b1;
    if ((s.regs[REG_MODE][4:3] & ~next_s.regs[REG_MODE][4:3]) != 2'h0 &&
        pend(next_s.regs))
      next_s.gap = 16'(INT_GAP_CYCLES); // [RULE23]
    else if (s.gap != 16'h0000)
      next_s.gap = s.gap - 16'h0001;

    // blink and ramp per sink
    for (int i = 0; i < 3; i++)
    begin
      en = s.regs[REG_SINK_CFG][i];
      dsel = s.regs[REG_BLINK][2*i+2 +: 2]; // [RULE7]
      tgt = s.regs[int'(REG_SINK0) + i][5:0];
      if (!en)
      begin
        tgt = 6'h00; // [RULE10] [RULE11]
        next_s.lit[i] = 1'b1;
        next_s.bcnt[i] = 16'h0000;
      end
      else if (dsel != 2'h0)
      begin
        if (!s.lit[i])
          tgt = 6'h00; // [RULE9]
        per = s.lit[i] ? blink_ticks(s.regs[REG_BLINK][1:0], 1'b1)
                       : blink_ticks(dsel, 1'b0); // [RULE8] [RULE9]
        if (s.tick)
        begin
          if (s.bcnt[i] + 16'h0001 >= per)
          begin
            next_s.bcnt[i] = 16'h0000;
            next_s.lit[i] = ~s.lit[i];
          end
          else
            next_s.bcnt[i] = s.bcnt[i] + 16'h0001;
        end
      end
      // same stepping for both curves; the sink maps codes by curve
      per = (tgt > s.code[i]) ? ramp_step_ticks(s.regs[REG_RAMP][3:0])
                              : ramp_step_ticks(s.regs[REG_RAMP][7:4]);
      if (tgt == s.code[i])
        next_s.stepc[i] = 16'h0000;
      else if (per == 16'h0000)
        next_s.code[i] = tgt; // [RULE1] [RULE2]
      else if (s.tick)
      begin
        if (s.stepc[i] + 16'h0001 >= per)
        begin
          next_s.stepc[i] = 16'h0000;
          next_s.code[i] = (tgt > s.code[i]) ? s.code[i] + 6'h01
                                             : s.code[i] - 6'h01; // [RULE24]
        end
        else
          next_s.stepc[i] = s.stepc[i] + 16'h0001; // [RULE3]
      end
    end

    if (hold)
    begin
      next_s.regs = '0; // [RULE13] [RULE19]
      next_s.st = I_IDLE;
      next_s.drive = 1'b0;
      next_s.ptr = RESET_VALUE;
      next_s.code = '0;
      next_s.stepc = '0;
      next_s.bcnt = '0;
      next_s.lit = '0;
      next_s.gap = 16'h0000;
    end
    next_s.int_on = pend(next_s.regs) && next_s.gap == 16'h0000; // [RULE21]
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign sda_out = 1'b0;
  assign sda_oe = s.drive; // [RULE15]
  assign int_n_out = 1'b0;
  assign int_n_oe = s.int_on; // [RULE12]
  assign aux_sink_code0 = s.code[0];
  assign aux_sink_code1 = s.code[1];
  assign aux_sink_code2 = s.code[2];
  assign aux_curve_select = s.regs[REG_SINK_CFG][CURVE_BIT]; // [RULE5] [RULE6]

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  ack_drive_a: assert property ( // [RULE15]
    (s.st == I_ACK_REG || s.st == I_ACK_DATA) |-> sda_oe)
    else $error("no ack drive");
  addr_match_a: assert property ( // [RULE14]
    ($past(s.st) == I_ADDR && s.st == I_ACK_ADDR) |->
      $past(s.sh[7:1]) == DEV_ADDR)
    else $error("acked foreign address");
  int_pend_a: assert property ( // [RULE21]
    int_n_oe |-> pend(s.regs) && s.gap == 16'h0000)
    else $error("interrupt without enabled flag");
  gap_hold_a: assert property ( // [RULE23]
    $rose(s.gap != 16'h0000) |-> !int_n_oe [*8])
    else $error("interrupt release too short");
  step_one_a: assert property ( // [RULE24]
    (s.regs[REG_RAMP][3:0] != 4'h0 && s.regs[REG_RAMP][7:4] != 4'h0 &&
     !hold) |=> (s.code[0] == $past(s.code[0]) ||
      s.code[0] == $past(s.code[0]) + 6'h01 ||
      s.code[0] == $past(s.code[0]) - 6'h01))
    else $error("ramp jumped more than one code");
  dark_stay_a: assert property ( // [RULE11]
    (!s.regs[REG_SINK_CFG][0] && s.code[0] == 6'h00) |=> s.code[0] == 6'h00)
    else $error("disabled sink relit");
  rst_hold_a: assert property ( // [RULE13]
    hold |=> s.regs == '0 && s.code == '0)
    else $error("pin reset did not clear state");
  unused_zero_a: assert property ( // [RULE19]
    s.regs[REG_SINK0][7:6] == 2'h0 && s.regs[REG_MODE][2:0] == 3'h0)
    else $error("unused bits not zero");
  ro_code_a: assert property ( // [RULE20]
    ($past(s.st) == I_ACK_ADDR && s.st == I_READ && s.ptr == REG_BL_CODE)
      |-> s.sh == {1'b0, $past(bl_applied_code)})
    else $error("wrong backlight code read");
endmodule // lstir_top

/* File: tb/lstir_host.sv */
// behavioural two-wire bus master standing in for the host processor
// assumes the bench ands this driver with the device onto a pulled-up wire
`timescale 1ns/1ps
module lstir_host #(
  parameter int HALF_NS = 80
) (
  input wire logic sda_wire,
  output logic scl,
  output logic sda_drive
);
  logic [2:0] acks;
  logic [7:0] rx;
  initial
  begin
    scl = 1'b1;
    sda_drive = 1'b1;
  end
  // one clock pulse; data moves a little after the low edge
  task automatic clk_bit(input logic o, output logic i);
    #(HALF_NS / 4);
    sda_drive = o;
    #(HALF_NS - HALF_NS / 4);
    scl = 1'b1;
    #(HALF_NS / 2);
    i = sda_wire;
    #(HALF_NS / 2);
    scl = 1'b0;
  endtask
  // also serves as repeated start; clock stands high between frames
  task automatic start_cond();
    sda_drive = 1'b1;
    #(HALF_NS);
    scl = 1'b1;
    #(HALF_NS);
    sda_drive = 1'b0;
    #(HALF_NS);
    scl = 1'b0;
  endtask
  task automatic stop_cond();
    #(HALF_NS / 4);
    sda_drive = 1'b0;
    #(HALF_NS);
    scl = 1'b1;
    #(HALF_NS);
    sda_drive = 1'b1;
    #(HALF_NS);
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic x;
    for (int k = 7; k >= 0; k--)
      clk_bit(d[k], x);
    clk_bit(1'b1, ack);
  endtask
  task automatic write_reg(input logic [7:0] dev, input logic [7:0] ra,
                           input logic [7:0] d);
    start_cond();
    send_byte(dev, acks[2]);
    send_byte(ra, acks[1]);
    send_byte(d, acks[0]);
    stop_cond();
  endtask
  task automatic read_reg(input logic [7:0] ra);
    logic x;
    start_cond();
    send_byte(8'h64, acks[2]);
    send_byte(ra, acks[1]);
    start_cond();
    send_byte(8'h65, acks[0]);
    for (int k = 7; k >= 0; k--)
      clk_bit(1'b1, rx[k]);
    clk_bit(1'b1, x);
    stop_cond();
  endtask
endmodule // lstir_host

/* File: tb/tb_led_sink_timing_i2c_regs.sv */
// self-checking bench for the aux led sink register block
// assumes lstir_host as bus master and pull-ups on sda and the irq line
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("BAD %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module tb_led_sink_timing_i2c_regs;
  import lstir_pkg::*;
  localparam int GAP = 30;
  typedef struct {
    logic [7:0] ra;
    logic [7:0] wd;
    logic [7:0] rd;
  } lstir_row_type;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rst_pin_n = 1'b1;
  logic ovp_event = 1'b0;
  logic cmpr_event = 1'b0;
  logic [6:0] bl_applied_code = 7'h55;
  logic scl, sda_drive, sda_out, sda_oe, int_n_out, int_n_oe, curve;
  logic [CODE_W-1:0] code0, code1, code2;
  int miscompares = 0;
  int checks_done = 0;
  int gap_cnt = 0;
  int gap_base = 0;
  wire sda_wire = sda_drive & ~(sda_oe & ~sda_out);
  wire int_line = ~(int_n_oe & ~int_n_out);
  lstir_row_type rows [8] = '{'{8'h01, 8'hFF, 8'h1C},
    '{8'h14, 8'hFF, 8'h3F}, '{8'h17, 8'hFF, 8'h00},
    '{8'h0B, 8'hFF, 8'h55}, '{8'h13, 8'hA5, 8'hA5},
    '{8'h12, 8'hC6, 8'hC6}, '{8'h02, 8'h3C, 8'h3C},
    '{8'h00, 8'hE0, 8'hE0}};
  lstir_top #(
    .TICK_CYCLES(10),
    .RST_DEB_CYCLES(20),
    .INT_GAP_CYCLES(GAP)
  ) lstir_top_inst (
    .clk(clk),
    .rst_n(rst_n),
    .rst_pin_n(rst_pin_n),
    .scl(scl),
    .sda_in(sda_wire),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .int_n_out(int_n_out),
    .int_n_oe(int_n_oe),
    .ovp_event(ovp_event),
    .cmpr_event(cmpr_event),
    .bl_applied_code(bl_applied_code),
    .aux_sink_code0(code0),
    .aux_sink_code1(code1),
    .aux_sink_code2(code2),
    .aux_curve_select(curve)
  );
  lstir_host lstir_host_inst (
    .sda_wire(sda_wire),
    .scl(scl),
    .sda_drive(sda_drive)
  );
  always #5 clk = ~clk;
  // counts cycles with the irq line released
  always @(posedge clk)
    if (int_n_oe === 1'b0)
      gap_cnt <= gap_cnt + 1;
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] ra, input logic [7:0] wd);
    lstir_host_inst.write_reg(8'h64, ra, wd);
    `CHECK("write acks", 3'b000, lstir_host_inst.acks)
    wait_cyc(1);
  endtask
  task automatic rd(input logic [7:0] ra, input logic [7:0] exp);
    lstir_host_inst.read_reg(ra);
    `CHECK("read acks", 3'b000, lstir_host_inst.acks)
    `CHECK("read data", exp, lstir_host_inst.rx)
    wait_cyc(1);
  endtask
  task automatic pulse(input logic sel);
    ovp_event = ~sel;
    cmpr_event = sel;
    wait_cyc(1);
    ovp_event = 1'b0;
    cmpr_event = 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (80000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    wait_cyc(4);
    `CHECK("curve at reset", 1'b0, curve)
    rd(8'h13, 8'h00);
    foreach (rows[i])
    begin
      wr(rows[i].ra, rows[i].wd);
      rd(rows[i].ra, rows[i].rd);
    end
    lstir_host_inst.write_reg(8'h66, 8'h02, 8'h00);
    `CHECK("foreign acks", 3'b111, lstir_host_inst.acks)
    wait_cyc(1);
    $display("register map test done");
    wr(8'h01, 8'h00);
    pulse(1'b0);
    wait_cyc(3);
    `CHECK("irq masked", 1'b1, int_line)
    rd(8'h00, 8'hF0);
    wr(8'h01, 8'h0C);
    wait_cyc(3);
    `CHECK("irq pin", 1'b0, int_line)
    pulse(1'b1);
    gap_base = gap_cnt;
    wr(8'h00, 8'hF0);
    wait_cyc(GAP + 10);
    `CHECK("irq gap", GAP, gap_cnt - gap_base)
    `CHECK("irq back", 1'b0, int_line)
    wr(8'h00, 8'hE8);
    wait_cyc(3);
    `CHECK("irq idle", 1'b1, int_line)
    $display("interrupt test done");
    rst_pin_n = 1'b0;
    wait_cyc(10);
    rst_pin_n = 1'b1;
    rd(8'h02, 8'h3C);
    rst_pin_n = 1'b0;
    wait_cyc(30);
    rst_pin_n = 1'b1;
    wait_cyc(4);
    rd(8'h02, 8'h00);
    $display("reset pin test done");
    wr(8'h13, 8'h11);
    wr(8'h14, 8'h02);
    wr(8'h11, 8'h01);
    wait_cyc(600);
    `CHECK("ramp step", 6'h01, code0)
    wait_cyc(500);
    `CHECK("ramp end", 6'h02, code0)
    $display("ramp test done");
    wr(8'h11, 8'h00);
    wr(8'h13, 8'h00);
    wr(8'h15, 8'h2A);
    wr(8'h16, 8'h15);
    wr(8'h12, 8'h14);
    wr(8'h11, 8'h0F);
    wait_cyc(100);
    `CHECK("lit sink0", 6'h02, code0)
    `CHECK("lit sink1", 6'h2A, code1)
    `CHECK("steady sink2", 6'h15, code2)
    `CHECK("curve", 1'b1, curve)
    wr(8'h11, 8'h0D);
    wait_cyc(10);
    `CHECK("cut while lit", 6'h00, code1)
    wait_cyc(18800);
    `CHECK("still lit", 6'h02, code0)
    wait_cyc(1200);
    `CHECK("dark sink0", 6'h00, code0)
    `CHECK("no blink sink2", 6'h15, code2)
    wr(8'h11, 8'h0C);
    wait_cyc(100);
    `CHECK("cut while dark", 6'h00, code0)
    $display("blink test done");
    print_verdict();
  end
endmodule // tb_led_sink_timing_i2c_regs
